// ==== cdsp_defs.svh ====
`ifndef CDSP_DEFS_SVH
`define CDSP_DEFS_SVH
// Summary of operation
// - Commands execute only on strobe falling edge.
// - Command clock also clocks subcode Q out.
// - Ready flag shows Q byte standing by.
// - Subcode frame sync falls entering standby, except when a crystal frame tick in the same cycle sets it.
// - Crystal frame sync is divided 7.35 kHz.
// - Reference clocks at 16.9344/33.8688 and 4.2336 MHz.
// - Noise mode rejects command clock glitches under 500 ns.

// ============================================================
// Clock and timing
`define CDSP_CLK_HZ     100000000
`define CDSP_FRAME_HZ   7350
`define CDSP_FRAME_HALF (`CDSP_CLK_HZ / (2 * `CDSP_FRAME_HZ))
`define CDSP_NR_NS      500
`define CDSP_NR_CYC     ((`CDSP_NR_NS * (`CDSP_CLK_HZ / 1000000) + 999) / 1000)
`define CDSP_REF_HZ     16934400
`define CDSP_QUAD_HZ    33868800
`define CDSP_QTR_HZ     4233600

// ============================================================
// Command codes and sizes
`define CDSP_CMD_NR_ON  8'hEF
`define CDSP_CMD_NR_OFF 8'hEE
`define CDSP_FIFO_W     8
`define CDSP_FIFO_D     8
`define CDSP_SQ_BITS    4'h8
`endif

// ==== cdsp_pkg.sv ====
// ============================================================
// Shared types of the command and subcode port.
package cdsp_pkg;
    // Number of whole command bytes received in a strobe window.
    typedef enum logic [1:0] {
        RX_EMPTY = 2'b00,
        RX_ONE   = 2'b01,
        RX_TWO   = 2'b10,
        RX_OVER  = 2'b11
    } cdsp_rx_e;
    // One command or subcode byte.
    typedef logic [7:0] cdsp_byte_t;
endpackage

// ==== cdsp_port.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cdsp_defs.svh"

// ============================================================
// Subcode Q byte buffer with registered ready and valid.
module cdsp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    output var  logic [W-1:0] out_data,
    output var  logic         out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];   // Storage words.
    logic [AW-1:0] wr_q;        // Write index.
    logic [AW-1:0] rd_q;        // Read index.
    logic [AW:0]   cnt_q;       // Words held.
    logic [AW:0]   cnt_d;       // Next word count.
    logic          push;        // Word accepted this cycle.
    logic          pop;         // Word drained this cycle.

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // Next count follows pushes and pops.
    always_comb begin
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointers, count and honest full and empty flags.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q      <= '0;
            rd_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'h1;
            out_valid <= 1'h0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q     <= cnt_d;
            in_ready  <= cnt_d != (AW+1)'(D);
            out_valid <= cnt_d != '0;
        end
    end

    // Data words are written without reset.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// ============================================================
// Command receiver, subcode Q readout and reference clocks.
module cdsp_port
    import cdsp_pkg::*;
#(
    parameter int FRAME_HALF = `CDSP_FRAME_HALF
) (
    input  wire logic       CLOCK,
    input  wire logic       ARST_N,
    input  wire logic       RW_STROBE,
    input  wire logic       CMD_DATA_IN,
    input  wire logic       CMD_SHIFT_CLK,
    input  wire logic       QUAD_SPEED,
    input  wire logic [7:0] SUBQ_IN_DATA,
    input  wire logic       SUBQ_IN_VALID,
    output var  logic       SUBQ_IN_READY,
    output var  logic       SUBQ_SERIAL_OUT,
    output var  logic       SUBQ_READY_FLAG,
    output var  logic       SUBCODE_FRAME_SYNC,
    output var  logic       CRYSTAL_FRAME_SYNC,
    output var  logic       REF_CLK_OUT,
    output var  logic       QUARTER_REF_CLK_OUT,
    output var  logic       CMD_VALID,
    output var  logic [7:0] CMD_CODE,
    output var  logic [7:0] CMD_PARAM,
    output var  logic       CMD_TWO_BYTE,
    output var  logic       NOISE_FILTER_ON
);
    localparam int NR_CYC = `CDSP_NR_CYC;
    // Phase step of a 32-bit accumulator for a given output rate.
    function automatic logic [31:0] nco_inc(input int hz);
        return 32'((64'(hz) << 32) / 64'(`CDSP_CLK_HZ));
    endfunction

    logic       rw_prev_q;   // Strobe one cycle ago.
    logic       clk_f_q;     // Filtered command clock.
    logic       clk_prev_q;  // Filtered clock one cycle ago.
    logic [5:0] nr_cnt_q;    // Stable-time counter of the filter.
    cdsp_byte_t sh_q;        // Command shift register.
    logic [2:0] bit_q;       // Bits of the current byte.
    cdsp_rx_e   rx_q;        // Whole bytes received.
    cdsp_byte_t byte0_q;     // Command code.
    cdsp_byte_t byte1_q;     // Command parameter.
    cdsp_byte_t sq_sh_q;     // Subcode Q output shifter.
    logic [3:0] sq_cnt_q;    // Subcode bits left to read.
    logic [12:0] fr_cnt_q;   // Frame divider count.
    logic [31:0] acc_q;      // Reference clock accumulator.
    logic [31:0] acc4_q;     // Quarter clock accumulator.
    logic       frame_tick;  // Crystal frame sync rises now.
    logic       ready_d;     // Next standby flag.
    logic       pop;         // Load the next subcode byte.
    logic [7:0] fifo_data;   // Head word of the buffer.
    logic       fifo_valid;  // Buffer holds a word.
    // Edge strobes from one cycle of input history.
    wire logic  rw_rise  = RW_STROBE && !rw_prev_q;
    wire logic  rw_fall  = !RW_STROBE && rw_prev_q;
    wire logic  clk_rise = clk_f_q && !clk_prev_q;

    // ============================================================
    // Input history for edge detection.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rw_prev_q  <= 1'h0;
            clk_prev_q <= 1'h0;
        end else begin
            rw_prev_q  <= RW_STROBE;
            clk_prev_q <= clk_f_q;
        end
    end

    // Glitch filter: in noise mode a level must hold NR_CYC cycles.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            clk_f_q  <= 1'h0;
            nr_cnt_q <= '0;
        end else if (!NOISE_FILTER_ON) begin
            clk_f_q  <= CMD_SHIFT_CLK;
            nr_cnt_q <= '0;
        end else if (CMD_SHIFT_CLK == clk_f_q) begin
            nr_cnt_q <= '0;
        end else if (nr_cnt_q == 6'(NR_CYC - 1)) begin
            clk_f_q  <= CMD_SHIFT_CLK;
            nr_cnt_q <= '0;
        end else begin
            nr_cnt_q <= nr_cnt_q + 6'h1;
        end
    end

    // ============================================================
    // Command shifting; a rising strobe drops partial bits.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            sh_q    <= '0;
            bit_q   <= '0;
            rx_q    <= RX_EMPTY;
            byte0_q <= '0;
            byte1_q <= '0;
        end else if (rw_rise) begin
            bit_q <= '0;
            rx_q  <= RX_EMPTY;
        end else if (RW_STROBE && clk_rise) begin
            sh_q  <= {CMD_DATA_IN, sh_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
                // A full byte: first is the code, second the parameter.
                case (rx_q)
                    RX_EMPTY: begin
                        byte0_q <= {CMD_DATA_IN, sh_q[7:1]};
                        rx_q    <= RX_ONE;
                    end
                    RX_ONE: begin
                        byte1_q <= {CMD_DATA_IN, sh_q[7:1]};
                        rx_q    <= RX_TWO;
                    end
                    default: begin
                        rx_q <= RX_OVER;
                    end
                endcase
            end
        end
    end

    // Execution at the strobe fall; malformed frames are dropped.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_VALID       <= 1'h0;
            CMD_CODE        <= '0;
            CMD_PARAM       <= '0;
            CMD_TWO_BYTE    <= 1'h0;
            NOISE_FILTER_ON <= 1'h0;
        end else begin
            CMD_VALID <= 1'h0;
            if (rw_fall && (rx_q == RX_ONE || rx_q == RX_TWO)) begin
                CMD_VALID    <= 1'h1;
                CMD_CODE     <= byte0_q;
                CMD_TWO_BYTE <= rx_q == RX_TWO;
                CMD_PARAM    <= (rx_q == RX_TWO) ? byte1_q : 8'h00;
                if (byte0_q == `CDSP_CMD_NR_ON) begin
                    NOISE_FILTER_ON <= 1'h1;
                end else if (byte0_q == `CDSP_CMD_NR_OFF) begin
                    NOISE_FILTER_ON <= 1'h0;
                end
            end
        end
    end

    // ============================================================
    // Subcode Q readout, clocked out by the command clock.
    cdsp_fifo #(
        .W(`CDSP_FIFO_W),
        .D(`CDSP_FIFO_D)
    ) u_fifo (
        .clk      (CLOCK),
        .arst_n   (ARST_N),
        .in_data  (SUBQ_IN_DATA),
        .in_valid (SUBQ_IN_VALID),
        .in_ready (SUBQ_IN_READY),
        .out_data (fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    assign pop = fifo_valid && sq_cnt_q == 4'h0;
    // The flag drops with the first read rise, not a cycle after it.
    assign ready_d = !RW_STROBE &&
                     (pop || (sq_cnt_q == `CDSP_SQ_BITS && !clk_rise));
    // Load a byte when idle; each clock rise in read mode shifts it.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            sq_sh_q  <= '0;
            sq_cnt_q <= '0;
        end else if (pop) begin
            sq_sh_q  <= fifo_data;
            sq_cnt_q <= `CDSP_SQ_BITS;
        end else if (!RW_STROBE && clk_rise && sq_cnt_q != 4'h0) begin
            sq_sh_q  <= {1'h0, sq_sh_q[7:1]};
            sq_cnt_q <= sq_cnt_q - 4'h1;
        end
    end

    // Serial bit, standby flag and subcode frame sync.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            SUBQ_SERIAL_OUT    <= 1'h0;
            SUBQ_READY_FLAG    <= 1'h0;
            SUBCODE_FRAME_SYNC <= 1'h0;
        end else begin
            SUBQ_SERIAL_OUT <= pop ? fifo_data[0] : sq_sh_q[0];
            SUBQ_READY_FLAG <= ready_d;
            if (frame_tick) begin
                SUBCODE_FRAME_SYNC <= 1'h1;
            end else if (ready_d && !SUBQ_READY_FLAG) begin
                SUBCODE_FRAME_SYNC <= 1'h0;
            end
        end
    end

    // ============================================================
    // Crystal-derived frame sync and reference clocks.
    assign frame_tick = fr_cnt_q == 13'(FRAME_HALF - 1) &&
                        !CRYSTAL_FRAME_SYNC;

    // Frame divider toggles every FRAME_HALF cycles.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            fr_cnt_q           <= '0;
            CRYSTAL_FRAME_SYNC <= 1'h0;
        end else if (fr_cnt_q == 13'(FRAME_HALF - 1)) begin
            fr_cnt_q           <= '0;
            CRYSTAL_FRAME_SYNC <= !CRYSTAL_FRAME_SYNC;
        end else begin
            fr_cnt_q <= fr_cnt_q + 13'h1;
        end
    end

    // Accumulator tops form the reference clocks.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_q  <= '0;
            acc4_q <= '0;
        end else begin
            acc_q  <= acc_q + (QUAD_SPEED ? nco_inc(`CDSP_QUAD_HZ) :
                                            nco_inc(`CDSP_REF_HZ));
            acc4_q <= acc4_q + nco_inc(`CDSP_QTR_HZ);
        end
    end

    assign REF_CLK_OUT         = acc_q[31];
    assign QUARTER_REF_CLK_OUT = acc4_q[31];

    // ============================================================
    // Checks.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    sequence s_strobe_fell;
        $past(RW_STROBE, 2) && !$past(RW_STROBE);
    endsequence
    a_exec_at_fall:
    assert property (CMD_VALID |-> s_strobe_fell)
        else $error("Command executed without strobe fall");
    a_no_exec_high:
    assert property (RW_STROBE && $past(RW_STROBE) |-> !CMD_VALID)
        else $error("Command executed while strobe high");
    a_two_byte_exec:
    assert property (CMD_VALID |-> CMD_TWO_BYTE ==
                     ($past(rx_q) == RX_TWO))
        else $error("Byte count mismatch at execution");
    a_lsb_first:
    assert property (RW_STROBE && !rw_rise && clk_rise && bit_q == 3'h7 &&
                     rx_q == RX_EMPTY |=> byte0_q ==
                     {$past(CMD_DATA_IN), $past(sh_q[7:1])})
        else $error("Code byte not shifted lsb first");
    a_strobe_clears:
    assert property (rw_rise |=> bit_q == 3'h0 && rx_q == RX_EMPTY)
        else $error("Partial bits kept after strobe rise");
    a_readout_shift:
    assert property (!RW_STROBE && clk_rise && !pop && sq_cnt_q != 4'h0
                     |=> sq_cnt_q == $past(sq_cnt_q) - 4'h1)
        else $error("Readout clock did not advance subcode");
    a_ready_flag:
    assert property (SUBQ_READY_FLAG |-> sq_cnt_q == `CDSP_SQ_BITS &&
                     !$past(RW_STROBE))
        else $error("Ready flag without standing byte");
    a_sync_falls:
    assert property ($rose(SUBQ_READY_FLAG) && !$past(frame_tick)
                     |-> !SUBCODE_FRAME_SYNC)
        else $error("Frame sync high on entering standby");
    a_frame_period:
    assert property ($changed(CRYSTAL_FRAME_SYNC) |->
                     $past(fr_cnt_q) == 13'(FRAME_HALF - 1))
        else $error("Frame sync toggled off count");
    a_filter_hold:
    assert property ($changed(clk_f_q) && $past(NOISE_FILTER_ON) |->
                     $past(nr_cnt_q) == 6'(NR_CYC - 1))
        else $error("Filtered clock changed too early");
endmodule
`default_nettype wire

// ==== cdsp_host.sv ====
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Controller model: shifts commands in and clocks subcode out.
module cdsp_host (
    input  wire logic       clk,
    output var  logic       rw_strobe,
    output var  logic       cmd_data,
    output var  logic       cmd_clk,
    input  wire logic       subq_bit,
    output var  logic [7:0] rd_byte,
    output var  logic       rd_done
);
    int half = 4;  // Cycles per clock level; 110 keeps 1.1 us.

    // Idle levels at time zero.
    initial begin
        rw_strobe = 1'b0;  // Low while reset is released.
        cmd_data  = 1'b0;
        cmd_clk   = 1'b0;  // The clock stands low between frames.
        rd_byte   = 8'h00;
        rd_done   = 1'b0;
    end

    // Waits a number of clock edges.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Drives one high pulse on the shared clock line.
    task automatic pulse(input int len);
        cmd_clk <= 1'b1;
        wait_cyc(len);
        cmd_clk <= 1'b0;
    endtask

    // Sends nbits LSB first in one strobe window.
    task automatic send(input logic [23:0] data, input int nbits,
                        input bit glitch);
        @(posedge clk);
        rw_strobe <= 1'b1;  // The window stays open for all bits.
        for (int i = 0; i < nbits; i++) begin
            wait_cyc(2);
            cmd_data <= data[i];  // Stable across its rise.
            if (glitch) begin
                wait_cyc(half);
                pulse(20);  // A spike the filter must drop.
            end
            wait_cyc(half);
            pulse(half);  // Levels held by half.
        end
        wait_cyc(half);
        rw_strobe <= 1'b0;  // The fall executes the command.
        cmd_data  <= ~cmd_data;  // A released line shows the inverse.
        wait_cyc(3);
    endtask

    // Reads one subcode byte, sampling each bit while clock is low.
    task automatic read_byte();
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wait_cyc(half);
            b[i] = subq_bit;
            pulse(half);  // The command clock reads out too.
        end
        rd_byte <= b;
        rd_done <= 1'b1;
        wait_cyc(1);
        rd_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Self-checking bench for the command and subcode port.
module tb_top;
    localparam int FH = 20;  // Short frame half period.
    logic       clk, arst_n, quad, sq_valid, sq_ready;  // Stimulus.
    logic       strobe, cdata, cclk, sq_bit, rdy, fsync;  // Port pins.
    logic       cfs, ref_clk, qtr_clk, cv, two, nf, rd_done;  // Outputs.
    logic [7:0] sq_data, code, param, rd_byte, c, p, b;  // Bytes.
    logic [23:0] cmd_q[$];  // Expected commands.
    logic [7:0]  sq_q[$];  // Expected subcode bytes.
    logic        ref_p, qtr_p, rdy_p, cfs_p, cfs_pp, full;  // History.
    int          per, per_seen, n_ref, n_qtr, m, failures, cmp_count;

    // A 100 MHz clock.
    initial clk = 1'b0;
    always #5 clk = ~clk;

    cdsp_port #(.FRAME_HALF(FH)) dut (
        .CLOCK              (clk),
        .ARST_N             (arst_n),
        .RW_STROBE          (strobe),
        .CMD_DATA_IN        (cdata),
        .CMD_SHIFT_CLK      (cclk),
        .QUAD_SPEED         (quad),
        .SUBQ_IN_DATA       (sq_data),
        .SUBQ_IN_VALID      (sq_valid),
        .SUBQ_IN_READY      (sq_ready),
        .SUBQ_SERIAL_OUT    (sq_bit),
        .SUBQ_READY_FLAG    (rdy),
        .SUBCODE_FRAME_SYNC (fsync),
        .CRYSTAL_FRAME_SYNC (cfs),
        .REF_CLK_OUT        (ref_clk),
        .QUARTER_REF_CLK_OUT(qtr_clk),
        .CMD_VALID          (cv),
        .CMD_CODE           (code),
        .CMD_PARAM          (param),
        .CMD_TWO_BYTE       (two),
        .NOISE_FILTER_ON    (nf)
    );

    cdsp_host host (
        .clk      (clk),
        .rw_strobe(strobe),
        .cmd_data (cdata),
        .cmd_clk  (cclk),
        .subq_bit (sq_bit),
        .rd_byte  (rd_byte),
        .rd_done  (rd_done)
    );

    // Compares one value and counts the result.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t saw %h exp %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Waits for the subcode ready flag under a bound.
    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) begin
            failures++;
            print_verdict();
        end
    endtask

    // Counts clock output rises over 1000 cycles.
    task automatic measure(input bit q, input int lo);
        @(posedge clk);
        quad <= q;
        repeat (50) @(posedge clk);
        @(negedge clk);
        n_ref = 0;
        n_qtr = 0;
        repeat (1000) @(negedge clk);
        check(24'(n_ref >= lo && n_ref <= lo + 1), 24'h1);
        check(24'(n_qtr >= 42 && n_qtr <= 43), 24'h1);
    endtask

    // Matches each result with the oldest note and tracks periods.
    always @(posedge clk) begin
        if (cv === 1'b1) begin
            if (cmd_q.size() == 0)
                check(24'h1, 24'h0);
            else
                check({7'h0, two, param, code}, cmd_q.pop_front());
        end
        if (rd_done === 1'b1 && sq_q.size() > 0)
            check({16'h0, rd_byte}, {16'h0, sq_q.pop_front()});
        if (rdy === 1'b1 && rdy_p === 1'b0 &&
            cfs === cfs_p && cfs_p === cfs_pp)
            check({23'h0, fsync}, 24'h0);
        if (cfs === 1'b1 && cfs_p === 1'b0) begin
            if (per_seen != 0)
                check(24'(per), 24'(2 * FH));
            per_seen = 1;
            per = 1;
        end else
            per++;
        if (ref_clk === 1'b1 && ref_p === 1'b0)
            n_ref++;
        if (qtr_clk === 1'b1 && qtr_p === 1'b0)
            n_qtr++;
        ref_p = ref_clk;
        qtr_p = qtr_clk;
        rdy_p = rdy;
        cfs_pp = cfs_p;
        cfs_p = cfs;
    end

    // Cuts a hang short.
    initial begin
        #1000000;
        failures++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        arst_n   = 1'b0;
        quad     = 1'b0;
        sq_valid = 1'b0;
        sq_data  = 8'h00;
        void'($urandom(76));
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // One- and two-byte commands, some with trailing bits.
        for (int k = 0; k < 6; k++) begin
            c = 8'($urandom);
            p = 8'($urandom);
            if (c[7:1] == 7'h77)
                c = 8'h5A;  // Keeps the filter mode untouched.
            cmd_q.push_back({7'h0, k[0], k[0] ? p : 8'h00, c});
            host.send({8'h0, p, c}, (k[0] ? 16 : 8) + (k > 3 ? 3 : 0), 1'b0);
        end
        // Empty, three-byte and partial windows change nothing.
        for (int k = 0; k < 3; k++) begin
            host.send(24'($urandom), k == 0 ? 0 : (k == 1 ? 24 : 5), 1'b0);
            check({16'h0, code}, {16'h0, c});
        end
        // Filter mode: slow clock with short spikes before each bit.
        cmd_q.push_back(24'h0000EF);
        host.send(24'h0000EF, 8, 1'b0);
        check({23'h0, nf}, 24'h1);
        host.half = 110;
        cmd_q.push_back({8'h01, p, c});
        host.send({8'h0, p, c}, 16, 1'b1);
        cmd_q.push_back(24'h0000EE);
        host.send(24'h0000EE, 8, 1'b1);
        check({23'h0, nf}, 24'h0);
        host.half = 4;
        // Fill the buffer until it refuses, nobody reading.
        b = 8'($urandom);
        @(posedge clk);
        sq_data  <= b;
        sq_valid <= 1'b1;
        full = 1'b0;
        m = 0;
        while (!full && m < 20) begin
            @(posedge clk);
            if (sq_ready === 1'b1) begin
                sq_q.push_back(b);
                m++;
                b = 8'($urandom);
                sq_data <= b;
            end else
                full = 1'b1;
        end
        repeat (4) @(posedge clk);
        sq_valid <= 1'b0;
        check({23'h0, full}, 24'h1);
        check({23'h0, rdy}, 24'h1);
        // A command in between must not shift subcode out.
        cmd_q.push_back({16'h0, c});
        host.send({16'h0, c}, 8, 1'b0);
        for (int i = 0; i < m; i++) begin
            wait_ready();
            host.read_byte();
        end
        repeat (20) @(posedge clk);
        check({23'h0, rdy}, 24'h0);
        check({23'h0, sq_ready}, 24'h1);
        measure(1'b0, 169);
        measure(1'b1, 338);
        check(24'(cmd_q.size() + sq_q.size()), 24'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
